//--- design/sdrmb_regs.svh
// Constants for the synchronous DRAM configuration and burst logic.
`ifndef SDRMB_REGS_SVH
`define SDRMB_REGS_SVH
`define SDRMB_CFG_W 13
`define SDRMB_CFG_RESET 13'h0020
`define SDRMB_BL_LSB 0
`define SDRMB_BL_MSB 2
`define SDRMB_ORDER_BIT 3
`define SDRMB_LAT_LSB 4
`define SDRMB_LAT_MSB 6
`define SDRMB_MODE_LSB 7
`define SDRMB_MODE_MSB 8
`define SDRMB_WBM_BIT 9
`define SDRMB_BL_1 3'h0
`define SDRMB_BL_2 3'h1
`define SDRMB_BL_4 3'h2
`define SDRMB_BL_8 3'h3
`define SDRMB_BL_FULL 3'h7
`define SDRMB_LAT_2 3'h2
`define SDRMB_LAT_3 3'h3
`define SDRMB_MODE_NORMAL 2'h0
`define SDRMB_ROW_W 13
`define SDRMB_COL_W 9
`define SDRMB_COL_LAST 9'h1ff
`define SDRMB_BANK_W 2
`define SDRMB_BANKS 4
`define SDRMB_DATA_W 16
`define SDRMB_AP_BIT 10
`define SDRMB_STORE_ROW_W 4
`define SDRMB_MEM_AW 15
`endif

//--- design/sdrmb_pkg.sv
// Types and shared functions for the synchronous DRAM burst logic.
`include "sdrmb_regs.svh"
package sdrmb_pkg;
    // Codes are the row strobe, column strobe and write enable levels.
    typedef enum logic [2:0] {
        CMD_LOAD = 3'h0,
        CMD_REFRESH = 3'h1,
        CMD_PRECHARGE = 3'h2,
        CMD_ACTIVE = 3'h3,
        CMD_WRITE = 3'h4,
        CMD_READ = 3'h5,
        CMD_TERM = 3'h6,
        CMD_NOP = 3'h7
    } sdrmb_cmd_type;

    typedef enum logic [1:0] {
        BURST_IDLE = 2'h0,
        BURST_READ = 2'h1,
        BURST_WRITE = 2'h2
    } sdrmb_burst_state_type;

    typedef struct packed {
        logic cs_n;
        logic ras_n;
        logic cas_n;
        logic we_n;
    } sdrmb_cmd_pins_type;

    typedef struct packed {
        logic [`SDRMB_COL_W-1:0] start;
        logic [`SDRMB_COL_W-1:0] step;
        logic [2:0] len;
        logic order;
    } sdrmb_seq_type;

    function automatic logic [`SDRMB_COL_W-1:0] sdrmb_blk_mask(input logic [2:0] len);
        case (len)
            `SDRMB_BL_2: return `SDRMB_COL_W'(1);
            `SDRMB_BL_4: return `SDRMB_COL_W'(3);
            `SDRMB_BL_8: return `SDRMB_COL_W'(7);
            `SDRMB_BL_FULL: return '1;
            default: return '0;
        endcase
    endfunction : sdrmb_blk_mask
endpackage : sdrmb_pkg

//--- design/sdrmb_colseq.sv
// Column address of one access within a burst.
`include "sdrmb_regs.svh"
module sdrmb_colseq (
    input wire sdrmb_pkg::sdrmb_seq_type seq,
    output logic [`SDRMB_COL_W-1:0] col
);
    import sdrmb_pkg::*;

    logic [`SDRMB_COL_W-1:0] mask;
    logic [`SDRMB_COL_W-1:0] low;

    always_comb begin
        mask = sdrmb_blk_mask(seq.len);
        // Full page never interleaves, so the order bit is ignored there.
        if (seq.order && seq.len != `SDRMB_BL_FULL) begin
            low = seq.start ^ seq.step;
        end else begin
            low = seq.start + seq.step;
        end
        col = (seq.start & ~mask) | (low & mask);
    end
endmodule : sdrmb_colseq

//--- design/sdrmb_rdpipe.sv
// Read data latency stage that places data on the data lines.
`include "sdrmb_regs.svh"
module sdrmb_rdpipe (
    input wire logic clk,
    input wire logic rst,
    input wire logic lat3,
    input wire logic in_valid,
    input wire logic [`SDRMB_DATA_W-1:0] in_data,
    output logic out_oe_n,
    output logic [`SDRMB_DATA_W-1:0] out_data
);
    logic s1_valid;
    logic [`SDRMB_DATA_W-1:0] s1_data;

    always_ff @(posedge clk) begin
        if (rst) begin
            s1_valid <= 1'b0;
            s1_data <= '0;
        end else begin
            s1_valid <= in_valid;
            s1_data <= in_data;
        end
    end

    // The extra stage is taken only when three cycles of latency are set.
    always_ff @(posedge clk) begin
        if (rst) begin
            out_oe_n <= 1'b1;
            out_data <= '0;
        end else if (lat3) begin
            out_oe_n <= ~s1_valid;
            out_data <= s1_data;
        end else begin
            out_oe_n <= ~in_valid;
            out_data <= in_data;
        end
    end
endmodule : sdrmb_rdpipe

//--- design/sdrmb_top.sv
// Command side of a four-bank synchronous DRAM: configuration, bursts, banks.
`include "sdrmb_regs.svh"
// Contract
// - All inputs sampled on rising clock edge.
// - Configuration changes only by configuration load.
// - Configuration bit fields: length, order, latency, mode.
// - Lengths 1,2,4,8 both orders; page sequential.
// - Full page runs until burst terminate.
// - Short bursts wrap inside aligned column block.
// - Full page wraps last column to zero.
// - Order bit selects sequential or interleaved.
// - Sequential adds step, interleaved XORs step.
// - Read latency two or three cycles.
// - Drive at n+m-1, data valid n+m.
// - Normal operation needs both mode bits zero.
// - Write burst mode bit forces single writes.
// - Activate takes bank select and row address.
// - Four independent banks, precharge per bank.
// - Auto precharge closes row after a burst of length 1 to 8 that completes; full page never auto precharges.
// - New column address accepted every cycle.
module sdrmb_top (
    input wire logic CLK,
    input wire logic RST,
    input wire sdrmb_pkg::sdrmb_cmd_pins_type CMD_PINS,
    input wire logic [`SDRMB_BANK_W-1:0] BANK_SELECT,
    input wire logic [`SDRMB_ROW_W-1:0] ADDR,
    input wire logic [`SDRMB_DATA_W-1:0] DATA_LINES_IN,
    output logic [`SDRMB_DATA_W-1:0] DATA_LINES_OUT,
    output logic DATA_LINES_OE_N,
    output logic [`SDRMB_BANKS-1:0] BANK_OPEN,
    output logic MODE_NORMAL
);
    import sdrmb_pkg::*;

    logic [`SDRMB_CFG_W-1:0] operating_config;
    sdrmb_cmd_type cmd;
    logic col_go;
    logic lat3;
    logic [2:0] cfg_len;
    logic [2:0] go_len;
    sdrmb_burst_state_type state;
    logic [`SDRMB_BANK_W-1:0] eng_bank;
    logic [`SDRMB_COL_W-1:0] eng_start;
    logic [`SDRMB_COL_W-1:0] eng_step;
    logic [`SDRMB_COL_W-1:0] eng_left;
    logic [2:0] eng_len;
    logic eng_order;
    logic eng_apre;
    logic [`SDRMB_ROW_W-1:0] bank_row [`SDRMB_BANKS];
    sdrmb_seq_type acc_seq;
    logic acc_valid;
    logic acc_write;
    logic [`SDRMB_BANK_W-1:0] acc_bank;
    logic [`SDRMB_COL_W-1:0] acc_col;
    logic [`SDRMB_MEM_AW-1:0] acc_index;
    logic burst_last;
    logic apre_last;
    logic [`SDRMB_DATA_W-1:0] mem [2**`SDRMB_MEM_AW];
    logic rd_valid;
    logic [`SDRMB_DATA_W-1:0] rd_data;

    // Pins are driven by controller logic on this same clock, so no synchroniser.
    always_comb begin
        if (CMD_PINS.cs_n) begin
            cmd = CMD_NOP;
        end else begin
            cmd = sdrmb_cmd_type'({CMD_PINS.ras_n, CMD_PINS.cas_n, CMD_PINS.we_n});
        end
    end

    assign col_go = (cmd == CMD_READ) || (cmd == CMD_WRITE);
    assign lat3 = operating_config[`SDRMB_LAT_MSB:`SDRMB_LAT_LSB] == `SDRMB_LAT_3;
    assign cfg_len = operating_config[`SDRMB_BL_MSB:`SDRMB_BL_LSB];

    // Reserved length codes fall back to single access.
    always_comb begin
        case (cfg_len)
            `SDRMB_BL_1, `SDRMB_BL_2, `SDRMB_BL_4, `SDRMB_BL_8, `SDRMB_BL_FULL: begin
                go_len = cfg_len;
            end
            default: begin
                go_len = `SDRMB_BL_1;
            end
        endcase
        if (cmd == CMD_WRITE && operating_config[`SDRMB_WBM_BIT]) begin
            go_len = `SDRMB_BL_1;
        end
    end

    // RST stands for power-up; after it only a load changes the register.
    always_ff @(posedge CLK) begin
        if (RST) begin
            operating_config <= `SDRMB_CFG_RESET;
            MODE_NORMAL <= 1'b1;
        end else if (cmd == CMD_LOAD) begin
            operating_config <= ADDR;
            MODE_NORMAL <= ADDR[`SDRMB_MODE_MSB:`SDRMB_MODE_LSB] == `SDRMB_MODE_NORMAL;
        end
    end

    // A fresh column command takes the current slot; otherwise the engine runs.
    always_comb begin
        // Data at the terminate edge is not valid, so no access is made there.
        acc_valid = col_go || (state != BURST_IDLE && cmd != CMD_TERM);
        if (col_go) begin
            acc_write = cmd == CMD_WRITE;
            acc_bank = BANK_SELECT;
            acc_seq.start = ADDR[`SDRMB_COL_W-1:0];
            acc_seq.step = '0;
            acc_seq.len = go_len;
            acc_seq.order = operating_config[`SDRMB_ORDER_BIT];
        end else begin
            acc_write = state == BURST_WRITE;
            acc_bank = eng_bank;
            acc_seq.start = eng_start;
            acc_seq.step = eng_step;
            acc_seq.len = eng_len;
            acc_seq.order = eng_order;
        end
    end

    sdrmb_colseq u_colseq (
        .seq(acc_seq),
        .col(acc_col)
    );

    assign acc_index = {acc_bank, bank_row[acc_bank][`SDRMB_STORE_ROW_W-1:0], acc_col};

    always_comb begin
        if (col_go) begin
            burst_last = sdrmb_blk_mask(go_len) == '0;
            apre_last = burst_last && ADDR[`SDRMB_AP_BIT];
        end else begin
            burst_last = (state != BURST_IDLE) && (eng_len != `SDRMB_BL_FULL)
                && (eng_left == `SDRMB_COL_W'(1)) && (cmd != CMD_TERM);
            apre_last = burst_last && eng_apre;
        end
    end

    always_ff @(posedge CLK) begin
        if (RST) begin
            state <= BURST_IDLE;
            eng_bank <= '0;
            eng_start <= '0;
            eng_step <= '0;
            eng_left <= '0;
            eng_len <= `SDRMB_BL_1;
            eng_order <= 1'b0;
            eng_apre <= 1'b0;
        end else if (col_go) begin
            eng_bank <= BANK_SELECT;
            eng_start <= ADDR[`SDRMB_COL_W-1:0];
            eng_step <= `SDRMB_COL_W'(1);
            eng_left <= sdrmb_blk_mask(go_len);
            eng_len <= go_len;
            eng_order <= operating_config[`SDRMB_ORDER_BIT];
            eng_apre <= ADDR[`SDRMB_AP_BIT];
            if (burst_last) begin
                state <= BURST_IDLE;
            end else if (cmd == CMD_WRITE) begin
                state <= BURST_WRITE;
            end else begin
                state <= BURST_READ;
            end
        end else if (cmd == CMD_TERM) begin
            state <= BURST_IDLE;
        end else if (state != BURST_IDLE) begin
            // Full page still counts down but never ends on the count, and wraps through the column field.
            eng_step <= eng_step + `SDRMB_COL_W'(1);
            eng_left <= eng_left - `SDRMB_COL_W'(1);
            if (burst_last) begin
                state <= BURST_IDLE;
            end
        end
    end

    // Banks open and close on their own, so one can precharge under another's burst.
    always_ff @(posedge CLK) begin
        if (RST) begin
            BANK_OPEN <= '0;
            for (int i = 0; i < `SDRMB_BANKS; i++) begin
                bank_row[i] <= '0;
            end
        end else begin
            if (cmd == CMD_ACTIVE) begin
                BANK_OPEN[BANK_SELECT] <= 1'b1;
                bank_row[BANK_SELECT] <= ADDR;
            end
            if (cmd == CMD_PRECHARGE) begin
                if (ADDR[`SDRMB_AP_BIT]) begin
                    BANK_OPEN <= '0;
                end else begin
                    BANK_OPEN[BANK_SELECT] <= 1'b0;
                end
            end
            if (apre_last) begin
                BANK_OPEN[acc_bank] <= 1'b0;
            end
        end
    end

    // Storage keeps only the low row bits, so rows that differ above them alias.
    always_ff @(posedge CLK) begin
        if (acc_valid && acc_write) begin
            mem[acc_index] <= DATA_LINES_IN;
        end
    end

    always_ff @(posedge CLK) begin
        if (RST) begin
            rd_valid <= 1'b0;
            rd_data <= '0;
        end else begin
            rd_valid <= acc_valid && !acc_write;
            rd_data <= mem[acc_index];
        end
    end

    sdrmb_rdpipe u_rdpipe (
        .clk(CLK),
        .rst(RST),
        .lat3(lat3),
        .in_valid(rd_valid),
        .in_data(rd_data),
        .out_oe_n(DATA_LINES_OE_N),
        .out_data(DATA_LINES_OUT)
    );

    logic [`SDRMB_COL_W-1:0] eng_mask;
    logic [`SDRMB_BANKS-1:0] sel_onehot;
    assign eng_mask = sdrmb_blk_mask(eng_len);
    assign sel_onehot = `SDRMB_BANKS'(1) << BANK_SELECT;

    property p_cfg_keep;
        @(posedge CLK) disable iff (RST)
        cmd != CMD_LOAD |=> operating_config == $past(operating_config);
    endproperty
    a_cfg_keep: assert property (p_cfg_keep) else $error("configuration changed without load");

    property p_cfg_load;
        @(posedge CLK) disable iff (RST)
        cmd == CMD_LOAD |=> operating_config == $past(ADDR);
    endproperty
    a_cfg_load: assert property (p_cfg_load) else $error("load did not capture address");

    sequence s_read_lat2;
        cmd == CMD_READ && !lat3;
    endsequence
    sequence s_read_lat3;
        cmd == CMD_READ && lat3;
    endsequence

    property p_lat2;
        @(posedge CLK) disable iff (RST)
        s_read_lat2 |-> ##2 !DATA_LINES_OE_N;
    endproperty
    a_lat2: assert property (p_lat2) else $error("latency two data not driven");

    property p_lat3;
        @(posedge CLK) disable iff (RST)
        s_read_lat3 |-> ##3 !DATA_LINES_OE_N;
    endproperty
    a_lat3: assert property (p_lat3) else $error("latency three data not driven");

    property p_block;
        @(posedge CLK) disable iff (RST)
        state != BURST_IDLE && !col_go && eng_len != `SDRMB_BL_FULL
            |-> (acc_col & ~eng_mask) == (eng_start & ~eng_mask);
    endproperty
    a_block: assert property (p_block) else $error("burst left its column block");

    sequence s_seq_run;
        state != BURST_IDLE && !col_go && !eng_order ##1 state != BURST_IDLE && !col_go;
    endsequence
    property p_seq_step;
        @(posedge CLK) disable iff (RST)
        s_seq_run |-> ((acc_col - $past(acc_col)) & eng_mask) == (`SDRMB_COL_W'(1) & eng_mask);
    endproperty
    a_seq_step: assert property (p_seq_step) else $error("sequential step wrong");

    property p_ilv;
        @(posedge CLK) disable iff (RST)
        state != BURST_IDLE && !col_go && eng_order && eng_len != `SDRMB_BL_FULL
            |-> ((acc_col ^ eng_start) & eng_mask) == (eng_step & eng_mask);
    endproperty
    a_ilv: assert property (p_ilv) else $error("interleaved order wrong");

    property p_page_wrap;
        @(posedge CLK) disable iff (RST)
        (state != BURST_IDLE && !col_go && eng_len == `SDRMB_BL_FULL
            && acc_col == `SDRMB_COL_LAST) ##1 (state != BURST_IDLE && !col_go)
            |-> acc_col == '0;
    endproperty
    a_page_wrap: assert property (p_page_wrap) else $error("full page did not wrap");

    property p_wsingle;
        @(posedge CLK) disable iff (RST)
        cmd == CMD_WRITE && operating_config[`SDRMB_WBM_BIT] |=> state == BURST_IDLE;
    endproperty
    a_wsingle: assert property (p_wsingle) else $error("write burst not single");

    property p_term;
        @(posedge CLK) disable iff (RST)
        cmd == CMD_TERM |=> state == BURST_IDLE;
    endproperty
    a_term: assert property (p_term) else $error("terminate did not stop burst");

    property p_apre;
        @(posedge CLK) disable iff (RST)
        apre_last && cmd != CMD_ACTIVE |=> !BANK_OPEN[$past(acc_bank)];
    endproperty
    a_apre: assert property (p_apre) else $error("auto precharge left row open");

    property p_act;
        @(posedge CLK) disable iff (RST)
        cmd == CMD_ACTIVE && !apre_last
            |=> BANK_OPEN[$past(BANK_SELECT)] && bank_row[$past(BANK_SELECT)] == $past(ADDR);
    endproperty
    a_act: assert property (p_act) else $error("activate did not open row");

    property p_other_banks;
        @(posedge CLK) disable iff (RST)
        cmd == CMD_PRECHARGE && !ADDR[`SDRMB_AP_BIT] && !apre_last
            |=> ((BANK_OPEN ^ $past(BANK_OPEN)) & ~$past(sel_onehot)) == '0;
    endproperty
    a_other_banks: assert property (p_other_banks) else $error("precharge hit other bank");

    property p_newcol;
        @(posedge CLK) disable iff (RST)
        col_go && !burst_last
            |=> eng_step == `SDRMB_COL_W'(1) && eng_start == $past(ADDR[`SDRMB_COL_W-1:0]);
    endproperty
    a_newcol: assert property (p_newcol) else $error("column command not taken");
endmodule : sdrmb_top

//--- sim/sdrmb_mc.sv
// Memory controller model that drives commands, addresses and write data.
module sdrmb_mc (
    input wire logic CLK,
    output sdrmb_pkg::sdrmb_cmd_pins_type pins,
    output logic [1:0] bank,
    output logic [12:0] addr,
    output logic [15:0] din
);
    timeunit 1ns;
    timeprecision 1ps;
    import sdrmb_pkg::*;
    initial begin
        pins = 4'hf;
        bank = 2'h0;
        addr = 13'h0000;
        din = 16'h0000;
    end
    // Changes land at the falling edge so that the rising edge sees settled values.
    task automatic cmd(input sdrmb_cmd_type c, input logic [1:0] b, input logic [12:0] a,
                       input logic [15:0] d);
        @(negedge CLK);
        pins <= {1'b0, c};
        bank <= b;
        addr <= a;
        din <= d;
    endtask : cmd
    // A deselected cycle shows the inverse of every released line, never a stale value.
    task automatic nop();
        @(negedge CLK);
        pins <= {1'b1, ~pins[2:0]};
        bank <= ~bank;
        addr <= ~addr;
        din <= ~din;
    endtask : nop
    // Loads only with every bank closed, then two idle cycles before anything else.
    task automatic load(input logic [12:0] cfg);
        cmd(CMD_PRECHARGE, 2'h0, 13'h0400, 16'h0000);
        nop();
        cmd(CMD_LOAD, 2'h0, cfg, 16'h0000);
        nop();
        nop();
    endtask : load
endmodule : sdrmb_mc

//--- sim/tb_top.sv
// Self-checking testbench for the synchronous DRAM command and burst logic.
`include "sdrmb_regs.svh"
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import sdrmb_pkg::*;
    localparam logic [12:0] ROW = 13'h01a5;
    logic CLK = 1'b0;
    logic RST = 1'b1;
    sdrmb_cmd_pins_type pins;
    logic [1:0] bank;
    logic [12:0] addr;
    logic [15:0] din;
    logic [15:0] dout;
    logic oe_n;
    logic normal;
    logic [3:0] bank_open;
    logic [15:0] mem [0:511];
    logic [2:0] cur_bl = `SDRMB_BL_1;
    logic cur_ord = 1'b0;
    logic wbm = 1'b0;
    int cur_lat = 2;
    int errors = 0;
    int n_checks = 0;

    sdrmb_top sdrmb_top_i (
        .CLK(CLK),
        .RST(RST),
        .CMD_PINS(pins),
        .BANK_SELECT(bank),
        .ADDR(addr),
        .DATA_LINES_IN(din),
        .DATA_LINES_OUT(dout),
        .DATA_LINES_OE_N(oe_n),
        .BANK_OPEN(bank_open),
        .MODE_NORMAL(normal)
    );
    sdrmb_mc sdrmb_mc_i (
        .CLK(CLK),
        .pins(pins),
        .bank(bank),
        .addr(addr),
        .din(din)
    );

    initial begin
        forever #2.5 CLK = ~CLK;
    end

    task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
        n_checks++;
        if (seen !== exp) begin
            errors++;
            $display("Error %s expected %h seen %h", name, exp, seen);
        end
    endtask : chk

    function automatic logic [8:0] colk(input logic [8:0] s, input int k);
        logic [8:0] m;
        logic [8:0] o;
        case (cur_bl)
            `SDRMB_BL_2: m = 9'h001;
            `SDRMB_BL_4: m = 9'h003;
            `SDRMB_BL_8: m = 9'h007;
            `SDRMB_BL_FULL: m = 9'h1ff;
            default: m = 9'h000;
        endcase
        o = (cur_ord && cur_bl != `SDRMB_BL_FULL) ? ((s & m) ^ k[8:0]) : ((s & m) + k[8:0]);
        return (s & ~m) | (o & m);
    endfunction : colk

    task automatic cfg(input logic [2:0] bl, input logic ord, input logic [2:0] lat,
                       input logic [1:0] md, input logic w);
        cur_bl = bl;
        cur_ord = ord;
        cur_lat = (lat == `SDRMB_LAT_3) ? 3 : 2;
        wbm = w;
        sdrmb_mc_i.load({3'h0, w, md, lat, ord, bl});
        sdrmb_mc_i.cmd(CMD_ACTIVE, 2'h0, ROW, 16'h0000);
        sdrmb_mc_i.nop();
    endtask : cfg

    task automatic wr(input logic [8:0] s, input int len, input logic [15:0] salt);
        logic [8:0] c;
        logic [15:0] d;
        for (int k = 0; k < len; k++) begin
            c = colk(s, k);
            d = {7'h5a, c} ^ salt;
            if (!wbm || k == 0) mem[c] = d;
            if (k == 0) sdrmb_mc_i.cmd(CMD_WRITE, 2'h0, {4'h0, s}, d);
            else sdrmb_mc_i.cmd(CMD_NOP, 2'h0, 13'h0000, d);
        end
        if (cur_bl == `SDRMB_BL_FULL) sdrmb_mc_i.cmd(CMD_TERM, 2'h0, 13'h0000, 16'h0000);
        sdrmb_mc_i.nop();
    endtask : wr

    task automatic rd(input logic [8:0] s, input int len, input logic ap);
        sdrmb_mc_i.cmd(CMD_READ, 2'h0, {2'h0, ap, 1'b0, s}, 16'h0000);
        sdrmb_mc_i.nop();
        repeat (cur_lat - 2) sdrmb_mc_i.nop();
        chk("oe_n before data", {15'h0, oe_n}, 16'h0001);
        for (int k = 0; k < len; k++) begin
            if (k == len - 1 && cur_bl == `SDRMB_BL_FULL) begin
                sdrmb_mc_i.cmd(CMD_TERM, 2'h0, 13'h0000, 16'h0000);
            end else begin
                sdrmb_mc_i.nop();
            end
            chk("oe_n data", {15'h0, oe_n}, 16'h0000);
            chk("read data", dout, mem[colk(s, k)]);
        end
        // The word accessed just before the terminate still drains; none follows it.
        if (cur_bl == `SDRMB_BL_FULL) sdrmb_mc_i.nop();
        sdrmb_mc_i.nop();
        chk("oe_n after", {15'h0, oe_n}, 16'h0001);
    endtask : rd

    task automatic final_report();
        if (errors == 0 && n_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : final_report

    initial begin
        repeat (3000) @(posedge CLK);
        errors++;
        final_report();
    end

    initial begin
        repeat (4) @(posedge CLK);
        @(negedge CLK);
        RST = 1'b0;
        chk("bank_open reset", {12'h0, bank_open}, 16'h0000);
        chk("oe_n reset", {15'h0, oe_n}, 16'h0001);
        chk("normal reset", {15'h0, normal}, 16'h0001);
        sdrmb_mc_i.cmd(CMD_ACTIVE, 2'h0, ROW, 16'h0000);
        sdrmb_mc_i.cmd(CMD_ACTIVE, 2'h2, ROW, 16'h0000);
        sdrmb_mc_i.nop();
        chk("bank_open active", {12'h0, bank_open}, 16'h0005);
        // Reset configuration is length one, sequential, latency two.
        wr(9'h0d0, 1, 16'h0000);
        rd(9'h0d0, 1, 1'b0);
        cfg(`SDRMB_BL_8, 1'b0, `SDRMB_LAT_2, 2'h0, 1'b0);
        wr(9'h008, 8, 16'h0000);
        for (int i = 0; i < 8; i++) begin
            cfg(3'(i / 2), 1'(i % 2), (i % 2) ? `SDRMB_LAT_3 : `SDRMB_LAT_2, 2'h0, 1'b0);
            rd(9'h00d, 1 << (i / 2), 1'b0);
        end
        cfg(`SDRMB_BL_4, 1'b0, `SDRMB_LAT_2, 2'h0, 1'b0);
        wr(9'h010, 4, 16'h0000);
        cfg(`SDRMB_BL_4, 1'b0, `SDRMB_LAT_2, 2'h0, 1'b1);
        wr(9'h011, 4, 16'hffff);
        rd(9'h010, 4, 1'b0);
        cfg(`SDRMB_BL_FULL, 1'b0, `SDRMB_LAT_2, 2'h0, 1'b0);
        wr(9'h1fe, 4, 16'h3c3c);
        rd(9'h1fe, 4, 1'b0);
        cfg(`SDRMB_BL_4, 1'b1, `SDRMB_LAT_3, 2'h0, 1'b0);
        sdrmb_mc_i.cmd(CMD_ACTIVE, 2'h2, ROW, 16'h0000);
        sdrmb_mc_i.nop();
        rd(9'h00e, 4, 1'b1);
        chk("bank_open auto precharge", {12'h0, bank_open}, 16'h0004);
        sdrmb_mc_i.cmd(CMD_PRECHARGE, 2'h2, 13'h0000, 16'h0000);
        sdrmb_mc_i.nop();
        chk("bank_open precharge", {12'h0, bank_open}, 16'h0000);
        cfg(`SDRMB_BL_1, 1'b0, `SDRMB_LAT_2, 2'h1, 1'b0);
        chk("normal test mode", {15'h0, normal}, 16'h0000);
        cfg(`SDRMB_BL_1, 1'b0, `SDRMB_LAT_2, 2'h0, 1'b0);
        chk("normal mode", {15'h0, normal}, 16'h0001);
        final_report();
    end
endmodule : tb_top
